// ### core/processor_control_word.sv
// Processor control word: APB register bank, external access wait-state
// sequencer, grant/enable pin, parallel flag pin direction, irq gating.
// Assumes a single 20 MHz clock, sync active-high reset, and that the
// access requester and irq flag producers share this clock.
//
// Behaviour
// - Partition B wait-state generator runs only when bit 0 is set.
// - Partition A wait-state generator runs only when bit 1 is set.
// - Bits 3:2 give B one, two, three waits, or ready-ended two plus.
// - Bits 5:4 give A one, two, three waits, or ready-ended two plus.
// - Every wait state lasts exactly one input clock period.
// - Bit 6 drives low flag nibble as outputs unless wide port set.
// - Bit 7 drives high flag nibble as outputs unless wide port set.
// - Bit 8 clear makes grant pin the external memory output enable.
// - Bit 8 set makes grant pin signal a pending external access.
// - In arbitration mode pin is inverted bit 9 OR internal pending.
// - Bits 15:10 individually enable or disable six interrupt sources.
// - Enables map to pin 2, tx empty, rx full, pout, pin, pin 1.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "pcw_map.svh"

module processor_control_word
  import pcw_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic ACCESS_REQ_IN,
  input wire logic ACCESS_PART_B_IN,
  input wire logic SLOW_READY_N_IN,
  output logic ACCESS_BUSY_OUT,
  output logic ACCESS_DONE_OUT,
  output logic GRANT_OR_ENABLE_N_OUT,
  input wire logic [7:0] PARALLEL_FLAG_PINS_IN,
  output logic [7:0] PARALLEL_FLAG_PINS_OUT,
  output logic [7:0] PARALLEL_FLAG_PINS_OE_N_OUT,
  input wire logic [5:0] IRQ_SOURCE_IN,
  output logic [5:0] IRQ_REQUEST_OUT
);

  // Wait plan for a delay count code
  // Code 11 loads the ready minimum first, so even a memory that
  // answers at once still gets its two wait states before the end.
  function automatic wait_plan_s plan_of(input logic [1:0] code);
    wait_plan_s p;
    p.ready_mode = 1'b0;
    unique case (code)
      `CNT_CODE_ONE: p.waits = 2'd1;
      `CNT_CODE_TWO: p.waits = 2'd2;
      `CNT_CODE_THREE: p.waits = 2'd3;
      `CNT_CODE_READY: begin
        p.waits = 2'(`READY_MIN_WAITS);
        p.ready_mode = 1'b1;
      end
    endcase
    return p;
  endfunction : plan_of

  // Glitch filter: output follows once stages two and three agree
  // A one-cycle spike on a pin never reaches the logic behind it,
  // at the price of one more cycle of latency on every real change.
  function automatic logic [7:0] agree(input logic [7:0] s2,
                                       input logic [7:0] s3,
                                       input logic [7:0] held);
    return (s2 & s3) | (held & (s2 | s3));
  endfunction : agree

  // Registers
  // Only the low half of each word is kept; the upper half of the
  // bus is ignored on writes and reads back as zero.
  logic [15:0] pcw_q;
  logic [15:0] pcw_d;
  logic [15:0] aux_q;
  logic [15:0] aux_d;
  pcw_s cfg;

  // APB response flops
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Sequencer
  seq_state_e state_q;
  seq_state_e state_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic ready_mode_q;
  logic ready_mode_d;
  logic busy_q;
  logic done_q;
  logic done_d;

  // Pin synchronisers
  logic [7:0] flag_s1_q;
  logic [7:0] flag_s2_q;
  logic [7:0] flag_s3_q;
  logic [7:0] flag_q;
  logic [7:0] rdy_s1_q;
  logic [7:0] rdy_s2_q;
  logic [7:0] rdy_s3_q;
  logic [7:0] rdy_q;
  logic [7:0] irq_s1_q;
  logic [7:0] irq_s2_q;
  logic [7:0] irq_s3_q;
  logic [7:0] irq_q;

  // Pin output flops
  logic grant_n_q;
  logic [7:0] flag_out_q;
  logic [7:0] flag_oe_n_q;
  logic [5:0] irq_out_q;

  // APB decode
  // The access phase is answered one cycle late, so answer marks the
  // first access cycle and commit the cycle in which pready stands.
  // Writes therefore land exactly at the edge the master samples.
  wire logic apb_access = PSEL_IN & PENABLE_IN;
  wire logic apb_answer = apb_access & ~pready_q;
  wire logic apb_commit = apb_access & pready_q;
  wire logic hit_config = PADDR_IN == `PCW_OFS_CONFIG;
  wire logic hit_status = PADDR_IN == `PCW_OFS_STATUS;
  wire logic hit_aux = PADDR_IN == `PCW_OFS_AUX;
  wire logic hit_any = hit_config | hit_status | hit_aux;
  wire logic wr_config = apb_commit & PWRITE_IN & hit_config;
  wire logic wr_aux = apb_commit & PWRITE_IN & hit_aux;

  // Field view of the control word
  assign cfg = pcw_s'(pcw_q);

  // Writes land only at the completing edge; fields act from next cycle
  assign pcw_d = wr_config ? PWDATA_IN[15:0] : pcw_q;
  assign aux_d = wr_aux ? PWDATA_IN[15:0] : aux_q;

  // Status word shows sequencer, filtered pins and gated irqs
  wire logic [31:0] status_word = {10'h000, irq_out_q, flag_q, 4'h0,
                                   ~rdy_q[0], busy_q, state_q};

  // Read mux; unmapped reads return zero with an error
  // Status is read-only: a write to it is accepted and dropped.
  wire logic [31:0] read_word =
    hit_config ? {16'h0000, pcw_q} :
    hit_status ? status_word :
    hit_aux ? {16'h0000, aux_q} : 32'h0000_0000;

  // Config registers
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      pcw_q <= `PCW_RESET;
      aux_q <= `AUX_RESET;
    end else begin
      pcw_q <= pcw_d;
      aux_q <= aux_d;
    end
  end

  // One wait cycle lets read data come from a flop
  // Read data is forced to zero outside the answer cycle so a stale
  // word never sits on the bus between transfers.
  // The error flag rides with pready and lasts the same one cycle.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_answer;
      prdata_q <= apb_answer ? read_word : 32'h0000_0000;
      pslverr_q <= apb_answer & ~hit_any;
    end
  end

  // Partition select and plan for the incoming request
  // Fields are read live, so a control word write takes effect on
  // the next request; an access already running keeps its plan.
  // A request is only seen while the sequencer sits idle.
  wire logic part_enabled = ACCESS_PART_B_IN ?
    cfg.partition_b_delay_enable :
    cfg.partition_a_delay_enable;
  wire logic [1:0] part_code = ACCESS_PART_B_IN ?
    cfg.partition_b_delay_count :
    cfg.partition_a_delay_count;
  wire wait_plan_s req_plan = plan_of(part_code);
  wire logic take_req = (state_q == SEQ_IDLE) & ACCESS_REQ_IN;
  wire logic ready_low = ~rdy_q[0];

  // Sequencer next state: one count step per clock is one wait state
  // Ready is only looked at from the last counted wait on, so an
  // early low on the pin cannot shorten the minimum.
  // A disabled generator finishes the access with no wait at all.
  // Limitation: ready waits have no timeout of their own.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ready_mode_d = ready_mode_q;
    done_d = 1'b0;
    unique case (state_q)
      SEQ_IDLE: begin
        if (take_req) begin
          if (part_enabled) begin
            state_d = SEQ_COUNT;
            cnt_d = req_plan.waits;
            ready_mode_d = req_plan.ready_mode;
          end else begin
            done_d = 1'b1; // Generator off: no wait states
          end
        end
      end
      SEQ_COUNT: begin
        cnt_d = cnt_q - 2'(`WAIT_STATE_CYCLES);
        if (cnt_q == 2'd1) begin
          if (ready_mode_q & ~ready_low) begin
            state_d = SEQ_READY;
          end else begin
            state_d = SEQ_IDLE;
            done_d = 1'b1;
          end
        end
      end
      SEQ_READY: begin
        if (ready_low) begin
          state_d = SEQ_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = SEQ_IDLE;
      end
    endcase
  end

  // Sequencer flops
  // Busy is taken from the next state so it rises with the first
  // wait and falls in the same cycle as the done pulse.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      state_q <= SEQ_IDLE;
      cnt_q <= 2'd0;
      ready_mode_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ready_mode_q <= ready_mode_d;
      done_q <= done_d;
      busy_q <= state_d != SEQ_IDLE;
    end
  end

  // Three-stage synchronisers; only stage two reads stage one
  // Ready stages reset high, its idle level, so no false ready
  // appears after reset. Unused ready and irq lanes are tied to the
  // idle level and fall away in synthesis.
  // Only the two pin-driven irq lines come from outside the clock.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      flag_s1_q <= 8'h00;
      flag_s2_q <= 8'h00;
      flag_s3_q <= 8'h00;
      flag_q <= 8'h00;
      rdy_s1_q <= 8'hff;
      rdy_s2_q <= 8'hff;
      rdy_s3_q <= 8'hff;
      rdy_q <= 8'hff;
      irq_s1_q <= 8'h00;
      irq_s2_q <= 8'h00;
      irq_s3_q <= 8'h00;
      irq_q <= 8'h00;
    end else begin
      flag_s1_q <= PARALLEL_FLAG_PINS_IN;
      flag_s2_q <= flag_s1_q;
      flag_s3_q <= flag_s2_q;
      flag_q <= agree(flag_s2_q, flag_s3_q, flag_q);
      rdy_s1_q <= {7'h7f, SLOW_READY_N_IN};
      rdy_s2_q <= rdy_s1_q;
      rdy_s3_q <= rdy_s2_q;
      rdy_q <= agree(rdy_s2_q, rdy_s3_q, rdy_q);
      irq_s1_q <= {6'h00, IRQ_SOURCE_IN[5], IRQ_SOURCE_IN[0]};
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      irq_q <= agree(irq_s2_q, irq_s3_q, irq_q);
    end
  end

  // Internal pending: a request waiting or an access in flight
  // The raw request is included so the arbiter hears of an access at
  // the edge the sequencer takes it, not one cycle later through busy.
  // Trade-off: a request dropped early still shows for one cycle.
  wire logic access_pending = ACCESS_REQ_IN | busy_q | (state_q != SEQ_IDLE);

  // Grant pin: output enable or inverted pending indicator
  // In enable mode the pin follows the next state so it is low for
  // every wait and for the done cycle, and high again right after.
  // The force bit is ignored unless the pin is in arbitration mode.
  wire logic grant_n_d = cfg.grant_or_enable_pin ?
    ~(cfg.access_request_force | access_pending) :
    ~(state_d != SEQ_IDLE | done_d);

  // Flag nibble directions; wide port takes the pins away
  // Output enables are active low and reset high, so both nibbles
  // come out of reset as inputs and never fight an outside driver.
  // Each nibble switches as a whole, never bit by bit.
  wire logic wide_port = aux_q[`AUX_BIT_WIDE_PORT];
  wire logic drive_lo = cfg.low_nibble_port_dir & ~wide_port;
  wire logic drive_hi = cfg.high_nibble_port_dir & ~wide_port;
  wire logic [7:0] flag_oe_n_d = ~{{4{drive_hi}}, {4{drive_lo}}};

  // Ext pin lines use the filtered copies, flags come in direct
  // The four internal flags share this clock and need no filter;
  // the pin lines lag by about four cycles through their filter.
  // Requests are levels: clearing the source or enable drops them.
  wire logic [5:0] irq_sources = {irq_q[1], IRQ_SOURCE_IN[4:1], irq_q[0]};
  // Enable bit 10 + i gates source i
  wire logic [5:0] irq_gated = irq_sources & cfg.irq_source_enables;

  // Pin output flops; grant and output enables reset high, flag data and irqs low
  // Every pin leaves from a flop so no decode glitch reaches a pad.
  // Flag output data comes from the auxiliary word.
  always_ff @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      grant_n_q <= 1'b1;
      flag_out_q <= 8'h00;
      flag_oe_n_q <= 8'hff;
      irq_out_q <= 6'h00;
    end else begin
      grant_n_q <= grant_n_d;
      flag_out_q <= aux_q[`AUX_LSB_FLAG_DATA +: 8];
      flag_oe_n_q <= flag_oe_n_d;
      irq_out_q <= irq_gated;
    end
  end

  // Outputs straight from flops
  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign ACCESS_BUSY_OUT = busy_q;
  assign ACCESS_DONE_OUT = done_q;
  assign GRANT_OR_ENABLE_N_OUT = grant_n_q;
  assign PARALLEL_FLAG_PINS_OUT = flag_out_q;
  assign PARALLEL_FLAG_PINS_OE_N_OUT = flag_oe_n_q;
  assign IRQ_REQUEST_OUT = irq_out_q;

endmodule : processor_control_word

// ### inc/pcw_map.svh
// Offsets, field positions, reset values and timing for the control word.
// Assumes inclusion by its bare name from the design and the bench.
`ifndef PCW_MAP_SVH
`define PCW_MAP_SVH

// Register byte addresses on the APB bus
`define PCW_OFS_CONFIG 12'h000
`define PCW_OFS_STATUS 12'h004
`define PCW_OFS_AUX 12'h008

// Control word field positions
`define PCW_BIT_B_EN 0
`define PCW_BIT_A_EN 1
`define PCW_LSB_B_CNT 2
`define PCW_LSB_A_CNT 4
`define PCW_BIT_LO_DIR 6
`define PCW_BIT_HI_DIR 7
`define PCW_BIT_GRANT_MODE 8
`define PCW_BIT_REQ_FORCE 9
`define PCW_LSB_IRQ_EN 10

// Auxiliary register fields
`define AUX_BIT_WIDE_PORT 0
`define AUX_LSB_FLAG_DATA 8

// Reset values
`define PCW_RESET 16'h0000
`define AUX_RESET 16'h0000

// Delay count codes
`define CNT_CODE_ONE 2'h0
`define CNT_CODE_TWO 2'h1
`define CNT_CODE_THREE 2'h2
`define CNT_CODE_READY 2'h3
`define READY_MIN_WAITS 2

// One wait state lasts one input clock period
`define CLK_PERIOD_NS 50
`define WAIT_STATE_NS 50
`define WAIT_STATE_CYCLES ((`WAIT_STATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### inc/pcw_pkg.sv
// Types shared by the control word block.
// Assumes the constant header pcw_map.svh is on the include path.
package pcw_pkg;

  // Access sequencer states, Gray along idle, counting, ready wait
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_COUNT = 2'h1,
    SEQ_READY = 2'h3
  } seq_state_e;

  // Control word layout, bit 15 first
  typedef struct packed {
    logic [5:0] irq_source_enables;
    logic access_request_force;
    logic grant_or_enable_pin;
    logic high_nibble_port_dir;
    logic low_nibble_port_dir;
    logic [1:0] partition_a_delay_count;
    logic [1:0] partition_b_delay_count;
    logic partition_a_delay_enable;
    logic partition_b_delay_enable;
  } pcw_s;

  // Decoded wait plan for one access
  typedef struct packed {
    logic [1:0] waits;
    logic ready_mode;
  } wait_plan_s;

endpackage : pcw_pkg

// ### verification/processor_control_word_sva.sv
// Port-level checks for the control word block.
// Assumes the one-wait APB answer and pulse outputs of the block.
`timescale 1ns/1ps
module pcw_checker (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic ACCESS_REQ_IN,
  input wire logic ACCESS_BUSY_OUT,
  input wire logic ACCESS_DONE_OUT,
  input wire logic [7:0] PARALLEL_FLAG_PINS_OE_N_OUT,
  input wire logic [5:0] IRQ_SOURCE_IN,
  input wire logic [5:0] IRQ_REQUEST_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  // Bus answer timing and framing
  apb_answer_a: assert property (
    PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
    else $error("apb answer late");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("pready held");
  err_pair_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("slverr alone");
  rdata_idle_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("read data outside answer");
  // Access sequencing
  done_idle_a: assert property (ACCESS_DONE_OUT |-> !ACCESS_BUSY_OUT)
    else $error("done while busy");
  busy_end_a: assert property (
    $fell(ACCESS_BUSY_OUT) |-> ACCESS_DONE_OUT)
    else $error("busy ended without done");
  access_bound_a: assert property (
    ACCESS_REQ_IN && !ACCESS_BUSY_OUT |-> ##[1:40] ACCESS_DONE_OUT)
    else $error("access never finished");
  // Same-clock irq sources only pass when present
  irq_gate_a: assert property (
    (IRQ_REQUEST_OUT[4:1] & ~$past(IRQ_SOURCE_IN[4:1])) == 4'h0)
    else $error("irq without source");
  lo_nibble_a: assert property (
    PARALLEL_FLAG_PINS_OE_N_OUT[3:0] inside {4'h0, 4'hf})
    else $error("low nibble split");
  hi_nibble_a: assert property (
    PARALLEL_FLAG_PINS_OE_N_OUT[7:4] inside {4'h0, 4'hf})
    else $error("high nibble split");
endmodule : pcw_checker

bind processor_control_word pcw_checker u_pcw_checker (
  .CORE_CLK_IN(CORE_CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .ACCESS_REQ_IN(ACCESS_REQ_IN), .ACCESS_BUSY_OUT(ACCESS_BUSY_OUT),
  .ACCESS_DONE_OUT(ACCESS_DONE_OUT),
  .PARALLEL_FLAG_PINS_OE_N_OUT(PARALLEL_FLAG_PINS_OE_N_OUT),
  .IRQ_SOURCE_IN(IRQ_SOURCE_IN), .IRQ_REQUEST_OUT(IRQ_REQUEST_OUT));

// ### verification/ext_mem_model.sv
// Far-side memory model answering the slow-ready handshake.
// Assumes the block's busy output marks a running access.
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic busy_in,
  input wire logic [3:0] delay_in,
  output logic ready_n_out
);
  logic [3:0] cnt_q;
  // Age of the running access, saturating
  always_ff @(posedge clk_in) begin
    if (rst_in || !busy_in) cnt_q <= 4'h0;
    else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
  end
  // Pulled high when no access runs, so no stale low leaks on
  assign ready_n_out = !(busy_in && cnt_q >= delay_in);
endmodule : ext_mem_model

// ### verification/tb_processor_control_word.sv
// Self-checking bench for the control word block.
// Assumes the memory model answers ready; all stimulus at clock edges.
`timescale 1ns/1ps
`include "pcw_map.svh"
module tb_processor_control_word;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, busy, done, gnt, rdy_n, gl;
  logic req = 1'b0, partb = 1'b0;
  logic [7:0] fin = 8'h00, fout, foe;
  logic [5:0] isrc = 6'h00, ireq;
  logic [3:0] dly = 4'h2;
  int err_total = 0, comparisons = 0;
  // 20 MHz core clock
  always #25 clk = ~clk;
  processor_control_word u_processor_control_word (.CORE_CLK_IN(clk),
    .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ACCESS_REQ_IN(req),
    .ACCESS_PART_B_IN(partb), .SLOW_READY_N_IN(rdy_n),
    .ACCESS_BUSY_OUT(busy), .ACCESS_DONE_OUT(done),
    .GRANT_OR_ENABLE_N_OUT(gnt), .PARALLEL_FLAG_PINS_IN(fin),
    .PARALLEL_FLAG_PINS_OUT(fout), .PARALLEL_FLAG_PINS_OE_N_OUT(foe),
    .IRQ_SOURCE_IN(isrc), .IRQ_REQUEST_OUT(ireq));
  ext_mem_model u_ext_mem_model (.clk_in(clk), .rst_in(rst),
    .busy_in(busy), .delay_in(dly), .ready_n_out(rdy_n));
  task automatic end_of_test;
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; an idle cycle before keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k == 20) begin
      err_total++;
      end_of_test();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wt
  // One external access; n is the cycle of the done pulse
  task automatic acc(input logic b, output int n);
    wt(6);
    @(posedge clk);
    req <= 1'b1;
    partb <= b;
    @(posedge clk);
    req <= 1'b0;
    n = 1;
    #1;
    gl = gnt;
    while (done !== 1'b1 && n < 40) begin
      wt(1);
      n++;
      gl &= gnt;
    end
    if (n == 40) begin
      err_total++;
      end_of_test();
    end
  endtask : acc
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, `PCW_OFS_CONFIG, 32'h0, r, e);
    chk("pcw reset", r, 32'h0);
    wr(`PCW_OFS_CONFIG, 32'hdead_a5c3);
    apb(1'b0, `PCW_OFS_CONFIG, 32'h0, r, e);
    chk("pcw readback", r, 32'h0000_a5c3);
    apb(1'b1, 12'h010, 32'h1, r, e);
    chk("unmapped err", e, 1'b1);
  endtask : t_regs
  // Fixed codes and a disabled generator, both partitions
  task automatic t_wait;
    int n, en, v;
    for (int p = 0; p < 2; p++) begin
      en = p ? 1 : 2;
      for (int c = 0; c < 4; c++) begin
        v = c == 3 ? (3 - en) + (2 << 2 * en) : en + (c << 2 * en);
        wr(`PCW_OFS_CONFIG, 32'(v));
        acc(p[0], n);
        chk("wait count", n, c == 3 ? 1 : c + 2);
      end
    end
  endtask : t_wait
  // Ready-ended code with prompt and slow memory
  task automatic t_ready;
    int n, en;
    for (int p = 0; p < 2; p++) begin
      en = p ? 1 : 2;
      wr(`PCW_OFS_CONFIG, 32'(en + (3 << 2 * en)));
      dly = 4'h2;
      acc(p[0], n);
      chk("ready prompt", n >= 3 && n < 12, 1'b1);
      dly = 4'h9;
      acc(p[0], n);
      chk("ready slow", n > 10 && n < 20, 1'b1);
    end
  endtask : t_ready
  task automatic t_flags;
    logic [31:0] r;
    logic e;
    @(posedge clk);
    fin <= 8'h3c;
    wr(`PCW_OFS_AUX, 32'h0000_a500);
    wr(`PCW_OFS_CONFIG, 32'h40);
    wt(2);
    chk("oe low nibble", foe, 8'hf0);
    wr(`PCW_OFS_CONFIG, 32'hc0);
    wt(2);
    chk("oe both", foe, 8'h00);
    chk("flag data", fout, 8'ha5);
    apb(1'b0, `PCW_OFS_STATUS, 32'h0, r, e);
    chk("flag inputs", r, 32'h0000_3c00);
    chk("status no err", e, 1'b0);
    wr(`PCW_OFS_AUX, 32'h0000_a501);
    wt(2);
    chk("oe wide port", foe, 8'hff);
  endtask : t_flags
  // Grant pin in output-enable and arbitration modes
  task automatic t_grant;
    int n;
    wr(`PCW_OFS_CONFIG, 32'h200);
    wt(2);
    chk("pin oe idle", gnt, 1'b1);
    acc(1'b1, n);
    chk("pin oe access", gl, 1'b0);
    wr(`PCW_OFS_CONFIG, 32'h100);
    wt(2);
    chk("pin arb idle", gnt, 1'b1);
    acc(1'b1, n);
    chk("pin arb pending", gl, 1'b0);
    wr(`PCW_OFS_CONFIG, 32'h300);
    wt(2);
    chk("pin forced", gnt, 1'b0);
  endtask : t_grant
  task automatic t_irq;
    @(posedge clk);
    isrc <= 6'h3f;
    for (int i = 0; i < 6; i++) begin
      wr(`PCW_OFS_CONFIG, 32'h400 << i);
      wt(8);
      chk("irq enable", ireq, 6'h01 << i);
    end
  endtask : t_irq
  // Reset, then every scenario in turn
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_wait();
    t_ready();
    t_flags();
    t_grant();
    t_irq();
    end_of_test();
  end
endmodule : tb_processor_control_word
